// ---- common/ccr_map.svh ----
// constants for the core data memory and special function register map
// assumes 8-bit direct addresses; register offsets are special function addresses
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH

`define CCR_ADDR_W 8
`define CCR_DATA_W 8
`define CCR_RAM_WORDS 256
`define CCR_SFR_WORDS 128

`define CCR_BANK_BYTES 8'h20
`define CCR_BITAREA_BASE 4'h2

`define CCR_SFR_PORT0 8'h80
`define CCR_SFR_STACK 8'h81
`define CCR_SFR_EPL 8'h82
`define CCR_SFR_EPH 8'h83
`define CCR_SFR_APL 8'h84
`define CCR_SFR_APH 8'h85
`define CCR_SFR_WDREL 8'h86
`define CCR_SFR_SPEED 8'h87
`define CCR_SFR_TCTL 8'h88
`define CCR_SFR_TMODE 8'h89
`define CCR_SFR_T0LO 8'h8a
`define CCR_SFR_T1LO 8'h8b
`define CCR_SFR_T0HI 8'h8c
`define CCR_SFR_T1HI 8'h8d
`define CCR_SFR_STRETCH 8'h8e
`define CCR_SFR_PORT1 8'h90
`define CCR_SFR_PORT1_DIRECTION 8'h91
`define CCR_SFR_PSEL 8'h92
`define CCR_SFR_ERASE 8'h94
`define CCR_SFR_S0CTL 8'h98
`define CCR_SFR_SERIAL0_BUFFER 8'h99
`define CCR_SFR_IRQ_ENABLE_2 8'h9a
`define CCR_SFR_S1CTL 8'h9b
`define CCR_SFR_S1BUF 8'h9c
`define CCR_SFR_S1RLO 8'h9d
`define CCR_SFR_EEDAT 8'h9e
`define CCR_SFR_EECMD 8'h9f
`define CCR_SFR_PORT2 8'ha0
`define CCR_SFR_PORT2_DIRECTION 8'ha1
`define CCR_SFR_PORT0_DIRECTION 8'ha2
`define CCR_SFR_IRQ_ENABLE_0 8'ha8
`define CCR_SFR_IPRI0 8'ha9
`define CCR_SFR_S0RLO 8'haa
`define CCR_SFR_FLCTL 8'hb2
`define CCR_SFR_PGNUM 8'hb7
`define CCR_SFR_IRQ_ENABLE_1 8'hb8
`define CCR_SFR_IPRI1 8'hb9
`define CCR_SFR_S0RHI 8'hba
`define CCR_SFR_S1RHI 8'hbb
`define CCR_SFR_PAGE 8'hbf
`define CCR_SFR_IRQREQ 8'hc0
`define CCR_SFR_IRQPOL 8'hc8
`define CCR_SFR_STATUS 8'hd0
`define CCR_SFR_BAUD 8'hd8
`define CCR_SFR_RESULT 8'he0
`define CCR_SFR_WDIRQ 8'he8
`define CCR_SFR_HELPER 8'hf0
`define CCR_SFR_IRQBITS 8'hf8

`define CCR_RST_PORT 8'hff
`define CCR_RST_STACK 8'h07
`define CCR_RST_STRETCH 8'h01
`define CCR_RST_S0RLO 8'hd9
`define CCR_RST_RELHI 8'h03
`define CCR_RST_PC 16'h0000

`define CCR_BAUD_MASK 8'h80
`define CCR_FLAG_CARRY 7
`define CCR_FLAG_HALF 6
`define CCR_FLAG_USER0 5
`define CCR_BANK_HI 4
`define CCR_BANK_LO 3
`define CCR_FLAG_WRAP 2
`define CCR_FLAG_USER1 1
`define CCR_FLAG_PARITY 0
`define CCR_PSEL_BIT 0

`endif

// ---- common/ccr_pkg.sv ----
// types for the core data memory and special function register block
// assumes ccr_map.svh is on the include path
`include "ccr_map.svh"

package ccr_pkg;

    // one access from the instruction sequencer
    typedef struct packed {
        logic valid;
        logic write;
        logic indirect;
        logic isBit;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic bitVal;
    } ccr_req_t;

    // side effects of executed instructions
    typedef struct packed {
        logic push;
        logic pop;
        logic [7:0] pushData;
        logic fetch;
        logic pcLoad;
        logic [15:0] pcValue;
        logic resultLoad;
        logic [7:0] resultValue;
        logic helperLoad;
        logic [7:0] helperValue;
        logic flagsLoad;
        logic carry;
        logic halfCarry;
        logic signedWrap;
        logic riSel;
    } ccr_evt_t;

    // registered view of the block for the sequencer and the chip
    typedef struct packed {
        logic [7:0] rdata;
        logic [7:0] popData;
        logic [15:0] extPointer;
        logic [15:0] pagedAddr;
        logic [15:0] fetchCounter;
        logic [7:0] result;
        logic [7:0] helper;
        logic [7:0] status;
        logic [7:0] stackTop;
        logic [7:0] bankBase;
        logic [2:0] stretch;
        logic [7:0] irqPolarity;
        logic baudHigh;
        logic [7:0] port0;
        logic [7:0] port1;
        logic [7:0] port2;
    } ccr_view_t;

    typedef struct packed {
        logic [255:0][7:0] ram;
        logic [127:0][7:0] sfr;
        logic [15:0] pc;
        ccr_view_t view;
    } ccr_state_t;

endpackage

// ---- logic/ccr_regfile.sv ----
// core internal data memory, special function registers and program counter
// assumes one clock, a synchronous active-low reset and a sequencer on the same clock
// What this block does
// - low 32 bytes are four banks of eight working registers
// - sixteen bytes above banks are bit addressable, bit addresses 0x00-0x7f
// - lower 128 bytes reachable by direct and indirect access
// - upper half: direct goes to special registers, indirect to ram
// - unimplemented special addresses read as zero, writes ignored
// - only special registers at multiples of eight are bit addressable
// - reset loads ports 0 and 1, stretch, stack top, serial reloads except S1RLO; other special registers clear
// - stack top resets to 0x07, pre-increments on push and call
// - status parity bit always tracks result register one-count parity
// - ext pointer is high:low byte registers, each writable alone
// - pointer select bit 0 picks primary or alternate pointer
// - fetch counter resets to zero, counts fetch events only, loads on pcLoad
// - helper register is multiply/divide operand, otherwise scratch
// - result register is the default operand and destination
// - paged external access takes high address byte from page register
// - polarity register sets active level of two extra interrupt inputs
// - baud select keeps only bit 7, other bits unused
`timescale 1ns/1ps
`default_nettype none
`include "ccr_map.svh"

module ccr_regfile (
    input wire logic clk,
    input wire logic resetn,
    input wire ccr_pkg::ccr_req_t req,
    input wire ccr_pkg::ccr_evt_t evt,
    input wire logic extIrq2In,
    input wire logic extIrq3In,
    output ccr_pkg::ccr_view_t view,
    output logic extIrq2Active,
    output logic extIrq3Active
);
    import ccr_pkg::*;

    localparam logic [6:0] IDX_STACK = 7'(`CCR_SFR_STACK);
    localparam logic [6:0] IDX_EPL = 7'(`CCR_SFR_EPL);
    localparam logic [6:0] IDX_EPH = 7'(`CCR_SFR_EPH);
    localparam logic [6:0] IDX_APL = 7'(`CCR_SFR_APL);
    localparam logic [6:0] IDX_APH = 7'(`CCR_SFR_APH);
    localparam logic [6:0] IDX_PSEL = 7'(`CCR_SFR_PSEL);
    localparam logic [6:0] IDX_STATUS = 7'(`CCR_SFR_STATUS);
    localparam logic [6:0] IDX_RESULT = 7'(`CCR_SFR_RESULT);
    localparam logic [6:0] IDX_HELPER = 7'(`CCR_SFR_HELPER);
    localparam logic [6:0] IDX_PAGE = 7'(`CCR_SFR_PAGE);
    localparam logic [6:0] IDX_STRETCH = 7'(`CCR_SFR_STRETCH);
    localparam logic [6:0] IDX_IRQPOL = 7'(`CCR_SFR_IRQPOL);
    localparam logic [6:0] IDX_BAUD = 7'(`CCR_SFR_BAUD);
    localparam logic [6:0] IDX_PORT0 = 7'(`CCR_SFR_PORT0);
    localparam logic [6:0] IDX_PORT1 = 7'(`CCR_SFR_PORT1);
    localparam logic [6:0] IDX_PORT2 = 7'(`CCR_SFR_PORT2);
    localparam logic [6:0] IDX_ERASE = 7'(`CCR_SFR_ERASE);

    ccr_state_t st_r;
    ccr_state_t st_nxt;
    logic irq2Sync1_r;
    logic irq2Sync2_r;
    logic irq3Sync1_r;
    logic irq3Sync2_r;
    logic irq2Act_r;
    logic irq3Act_r;

    // implemented special register addresses
    function automatic logic sfrImpl(input logic [7:0] a);
        case (a)
            `CCR_SFR_PORT0, `CCR_SFR_STACK, `CCR_SFR_EPL, `CCR_SFR_EPH,
            `CCR_SFR_APL, `CCR_SFR_APH, `CCR_SFR_WDREL, `CCR_SFR_SPEED,
            `CCR_SFR_TCTL, `CCR_SFR_TMODE, `CCR_SFR_T0LO, `CCR_SFR_T1LO,
            `CCR_SFR_T0HI, `CCR_SFR_T1HI, `CCR_SFR_STRETCH, `CCR_SFR_PORT1,
            `CCR_SFR_PORT1_DIRECTION, `CCR_SFR_PSEL, `CCR_SFR_ERASE, `CCR_SFR_S0CTL,
            `CCR_SFR_SERIAL0_BUFFER, `CCR_SFR_IRQ_ENABLE_2, `CCR_SFR_S1CTL, `CCR_SFR_S1BUF,
            `CCR_SFR_S1RLO, `CCR_SFR_EEDAT, `CCR_SFR_EECMD, `CCR_SFR_PORT2,
            `CCR_SFR_PORT2_DIRECTION, `CCR_SFR_PORT0_DIRECTION, `CCR_SFR_IRQ_ENABLE_0, `CCR_SFR_IPRI0,
            `CCR_SFR_S0RLO, `CCR_SFR_FLCTL, `CCR_SFR_PGNUM, `CCR_SFR_IRQ_ENABLE_1,
            `CCR_SFR_IPRI1, `CCR_SFR_S0RHI, `CCR_SFR_S1RHI, `CCR_SFR_PAGE,
            `CCR_SFR_IRQREQ, `CCR_SFR_IRQPOL, `CCR_SFR_STATUS, `CCR_SFR_BAUD,
            `CCR_SFR_RESULT, `CCR_SFR_WDIRQ, `CCR_SFR_HELPER, `CCR_SFR_IRQBITS:
                sfrImpl = 1'b1;
            default:
                sfrImpl = 1'b0;
        endcase
    endfunction

    always_comb begin
        logic sfrSide;
        logic [7:0] byteAddr;
        logic [7:0] cur;
        logic [7:0] upd;
        logic [7:0] spInc;
        logic [7:0] bankBase;
        logic [1:0] bank;
        sfrSide = 1'b0;
        byteAddr = 8'h00;
        cur = 8'h00;
        upd = 8'h00;
        spInc = 8'h00;
        bankBase = 8'h00;
        bank = 2'h0;
        st_nxt = st_r;

        // bit address decode into bytes 0x20-0x2f
        // bit access above 0x7f hits the multiple-of-eight register
        if (req.isBit) begin
            sfrSide = req.addr[7];
            byteAddr = req.addr[7] ? {req.addr[7:3], 3'h0} : {`CCR_BITAREA_BASE, req.addr[6:3]};
        end else begin
            // direct above 0x7f to special registers, indirect to ram
            sfrSide = req.addr[7] & ~req.indirect;
            byteAddr = req.addr;
        end

        // unimplemented and write-only addresses read as zero
        if (sfrSide) begin
            cur = (sfrImpl(byteAddr) && byteAddr != `CCR_SFR_ERASE) ? st_r.sfr[byteAddr[6:0]] : 8'h00;
        end else begin
            // whole ram reachable, banks and bit area included
            cur = st_r.ram[byteAddr];
        end

        if (req.valid && !req.write) begin
            st_nxt.view.rdata = req.isBit ? {7'h00, cur[req.addr[2:0]]} : cur;
        end

        if (req.valid && req.write) begin
            upd = cur;
            if (req.isBit) begin
                upd[req.addr[2:0]] = req.bitVal;
            end else begin
                upd = req.wdata;
            end
            if (sfrSide) begin
                if (sfrImpl(byteAddr)) begin
                    st_nxt.sfr[byteAddr[6:0]] = upd;
                end
            end else begin
                st_nxt.ram[byteAddr] = upd;
            end
        end

        // pre-increment on push, post-decrement on pop
        spInc = st_nxt.sfr[IDX_STACK] + 8'h01;
        if (evt.push) begin
            st_nxt.ram[spInc] = evt.pushData;
            st_nxt.sfr[IDX_STACK] = spInc;
        end else if (evt.pop) begin
            st_nxt.view.popData = st_r.ram[st_r.sfr[IDX_STACK]];
            st_nxt.sfr[IDX_STACK] = st_nxt.sfr[IDX_STACK] - 8'h01;
        end

        if (evt.pcLoad) begin
            st_nxt.pc = evt.pcValue;
        end else if (evt.fetch) begin
            st_nxt.pc = st_r.pc + 16'h0001;
        end

        // instruction result lands in result register
        if (evt.resultLoad) begin
            st_nxt.sfr[IDX_RESULT] = evt.resultValue;
        end
        if (evt.helperLoad) begin
            st_nxt.sfr[IDX_HELPER] = evt.helperValue;
        end
        // arithmetic flags at their bit positions
        if (evt.flagsLoad) begin
            st_nxt.sfr[IDX_STATUS][`CCR_FLAG_CARRY] = evt.carry;
            st_nxt.sfr[IDX_STATUS][`CCR_FLAG_HALF] = evt.halfCarry;
            st_nxt.sfr[IDX_STATUS][`CCR_FLAG_WRAP] = evt.signedWrap;
        end
        st_nxt.sfr[IDX_STATUS][`CCR_FLAG_PARITY] = ^st_nxt.sfr[IDX_RESULT];
        // baud select keeps bit 7 only
        st_nxt.sfr[IDX_BAUD] = st_nxt.sfr[IDX_BAUD] & `CCR_BAUD_MASK;
        st_nxt.sfr[IDX_ERASE] = 8'h00;

        // reset values of the special registers
        if (!resetn) begin
            st_nxt.sfr = '0;
            st_nxt.view = '0;
            st_nxt.sfr[IDX_PORT0] = `CCR_RST_PORT;
            st_nxt.sfr[IDX_PORT1] = `CCR_RST_PORT;
            st_nxt.sfr[IDX_STRETCH] = `CCR_RST_STRETCH;
            st_nxt.sfr[7'(`CCR_SFR_S0RLO)] = `CCR_RST_S0RLO;
            st_nxt.sfr[7'(`CCR_SFR_S0RHI)] = `CCR_RST_RELHI;
            st_nxt.sfr[7'(`CCR_SFR_S1RHI)] = `CCR_RST_RELHI;
            st_nxt.sfr[IDX_STACK] = `CCR_RST_STACK;
            st_nxt.pc = `CCR_RST_PC;
        end

        // active bank base from status bits 4 and 3
        bank = {st_nxt.sfr[IDX_STATUS][`CCR_BANK_HI], st_nxt.sfr[IDX_STATUS][`CCR_BANK_LO]};
        bankBase = {3'h0, bank, 3'h0};
        st_nxt.view.bankBase = bankBase;
        // paged address: page register over working register 0 or 1
        st_nxt.view.pagedAddr = {st_nxt.sfr[IDX_PAGE], st_nxt.ram[bankBase | {7'h00, evt.riSel}]};
        if (st_nxt.sfr[IDX_PSEL][`CCR_PSEL_BIT]) begin
            st_nxt.view.extPointer = {st_nxt.sfr[IDX_APH], st_nxt.sfr[IDX_APL]};
        end else begin
            st_nxt.view.extPointer = {st_nxt.sfr[IDX_EPH], st_nxt.sfr[IDX_EPL]};
        end
        st_nxt.view.fetchCounter = st_nxt.pc;
        st_nxt.view.result = st_nxt.sfr[IDX_RESULT];
        st_nxt.view.helper = st_nxt.sfr[IDX_HELPER];
        st_nxt.view.status = st_nxt.sfr[IDX_STATUS];
        st_nxt.view.stackTop = st_nxt.sfr[IDX_STACK];
        st_nxt.view.stretch = st_nxt.sfr[IDX_STRETCH][2:0];
        st_nxt.view.irqPolarity = st_nxt.sfr[IDX_IRQPOL];
        st_nxt.view.baudHigh = st_nxt.sfr[IDX_BAUD][7];
        st_nxt.view.port0 = st_nxt.sfr[IDX_PORT0];
        st_nxt.view.port1 = st_nxt.sfr[IDX_PORT1];
        st_nxt.view.port2 = st_nxt.sfr[IDX_PORT2];
    end

    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    // pins synchronised, then polarity bits 0 and 1 applied
    always_ff @(posedge clk) begin
        if (!resetn) begin
            irq2Sync1_r <= 1'b0;
            irq2Sync2_r <= 1'b0;
            irq3Sync1_r <= 1'b0;
            irq3Sync2_r <= 1'b0;
            irq2Act_r <= 1'b0;
            irq3Act_r <= 1'b0;
        end else begin
            irq2Sync1_r <= extIrq2In;
            irq2Sync2_r <= irq2Sync1_r;
            irq3Sync1_r <= extIrq3In;
            irq3Sync2_r <= irq3Sync1_r;
            irq2Act_r <= irq2Sync2_r ~^ st_r.sfr[IDX_IRQPOL][0];
            irq3Act_r <= irq3Sync2_r ~^ st_r.sfr[IDX_IRQPOL][1];
        end
    end

    assign view = st_r.view;
    assign extIrq2Active = irq2Act_r;
    assign extIrq3Active = irq3Act_r;

endmodule
`default_nettype wire

// ---- tb/ccr_regfile_chk.sv ----
// checker for the core register file, watching its ports only
// assumes one clock and the synchronous active-low reset of the block
`timescale 1ns/1ps
`default_nettype none

module ccr_regfile_chk (
    input wire logic clk,
    input wire logic resetn,
    input wire ccr_pkg::ccr_req_t req,
    input wire ccr_pkg::ccr_evt_t evt,
    input wire logic extIrq2In,
    input wire logic extIrq3In,
    input wire ccr_pkg::ccr_view_t view,
    input wire logic extIrq2Active,
    input wire logic extIrq3Active
);
    import ccr_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic wrStack;
    logic dirRd;
    logic dirWr;
    assign dirRd = req.valid && !req.write && !req.indirect && !req.isBit;
    assign dirWr = req.valid && req.write && !req.indirect && !req.isBit;
    assign wrStack = dirWr && req.addr == 8'h81;

    a_reset_load: assert property (disable iff (1'b0) !resetn |=>
        view.port0 == 8'hff && view.port1 == 8'hff && view.stackTop == 8'h07 && view.stretch == 3'h1)
        else $error("reset values wrong");
    a_parity_track: assert property (view.status[0] == ^view.result)
        else $error("parity bit wrong");
    a_bank_base: assert property (view.bankBase == {3'b000, view.status[4:3], 3'b000})
        else $error("bank base wrong");
    a_push_step: assert property (evt.push && !wrStack |=>
        view.stackTop == $past(view.stackTop) + 8'h01) else $error("push step wrong");
    a_pop_step: assert property (evt.pop && !evt.push && !wrStack |=>
        view.stackTop == $past(view.stackTop) - 8'h01) else $error("pop step wrong");
    a_fetch_step: assert property (evt.fetch && !evt.pcLoad |=>
        view.fetchCounter == $past(view.fetchCounter) + 16'h0001) else $error("fetch count wrong");
    a_jump_load: assert property (evt.pcLoad |=> view.fetchCounter == $past(evt.pcValue))
        else $error("jump load wrong");
    a_flag_load: assert property (evt.flagsLoad |=> view.status[7] == $past(evt.carry) &&
        view.status[6] == $past(evt.halfCarry) && view.status[2] == $past(evt.signedWrap))
        else $error("flag load wrong");
    a_unimpl_zero: assert property (dirRd && req.addr == 8'h93 |=> view.rdata == 8'h00)
        else $error("unimplemented read not zero");
    a_baud_bit: assert property (dirWr && req.addr == 8'hd8 |=>
        view.baudHigh == $past(req.wdata[7])) else $error("baud bit wrong");
    a_irq_level: assert property (($stable(extIrq2In) && $stable(view.irqPolarity))[*5] |->
        extIrq2Active == (extIrq2In ~^ view.irqPolarity[0])) else $error("irq level wrong");
    a_irq3_level: assert property (($stable(extIrq3In) && $stable(view.irqPolarity))[*5] |->
        extIrq3Active == (extIrq3In ~^ view.irqPolarity[1])) else $error("irq3 level wrong");
endmodule

bind ccr_regfile ccr_regfile_chk chkU (.clk(clk), .resetn(resetn), .req(req), .evt(evt),
    .extIrq2In(extIrq2In), .extIrq3In(extIrq3In), .view(view),
    .extIrq2Active(extIrq2Active), .extIrq3Active(extIrq3Active));

`default_nettype wire

// ---- tb/ccr_seq_model.sv ----
// instruction sequencer model issuing accesses and event pulses
// assumes requests are taken on the edge after they are driven
`timescale 1ns/1ps
`default_nettype none

module ccr_seq_model (
    input wire logic clk,
    output var ccr_pkg::ccr_req_t req,
    output var ccr_pkg::ccr_evt_t evt
);
    import ccr_pkg::*;
    initial begin
        req = '0;
        evt = '0;
    end
    task automatic acc(input logic w, input logic ind, input logic bt, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{valid: 1'b1, write: w, indirect: ind, isBit: bt, addr: a, wdata: d, bitVal: d[0]};
        @(posedge clk);
        // released address and data lines do not keep the old value
        req <= '{valid: 1'b0, write: w, indirect: ind, isBit: bt, addr: ~a, wdata: ~d, bitVal: ~d[0]};
        @(negedge clk);
    endtask
    task automatic ev(input ccr_evt_t e);
        @(posedge clk);
        evt <= e;
        @(posedge clk);
        // riSel is a level, so it stays until the next event call
        evt <= '{pushData: ~e.pushData, pcValue: ~e.pcValue, riSel: e.riSel, default: 0};
        @(negedge clk);
    endtask
endmodule

`default_nettype wire

// ---- tb/tb_cpu_core_register_map.sv ----
// self-checking bench for the core register file
// assumes the sequencer model drives req and evt
`timescale 1ns/1ps
`default_nettype none

module tb_cpu_core_register_map;
    import ccr_pkg::*;
    logic clk, resetn, pin2, pin3, act2, act3, pend;
    ccr_req_t req;
    ccr_evt_t evt;
    ccr_view_t view;
    int badCount, checked, cyc;
    logic [7:0] rnd;
    logic [7:0] q[$];
    logic [15:0] rstTab[10] = '{16'h80ff, 16'h8107, 16'h8e01, 16'h90ff, 16'haad9,
        16'hba03, 16'hbb03, 16'h9200, 16'hd000, 16'he000};

    ccr_regfile dut (.clk(clk), .resetn(resetn), .req(req), .evt(evt), .extIrq2In(pin2),
        .extIrq3In(pin3), .view(view), .extIrq2Active(act2), .extIrq3Active(act3));
    ccr_seq_model seq (.clk(clk), .req(req), .evt(evt));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            badCount++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic ind, input logic [7:0] a, input logic [7:0] d);
        seq.acc(1'b1, ind, 1'b0, a, d);
    endtask
    task automatic rd(input logic ind, input logic [7:0] a, input logic [7:0] e);
        q.push_back(e);
        seq.acc(1'b0, ind, 1'b0, a, 8'h00);
    endtask
    function automatic logic [7:0] nx(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // read results land on the edge that takes the read and are checked at the next falling edge
    always @(negedge clk) begin
        if (pend) begin
            chk(view.rdata, q.pop_front());
        end
        pend = resetn && req.valid && !req.write;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            badCount++;
            tally_and_finish();
        end
    end

    initial begin
        resetn = 1'b0;
        pin2 = 1'b0;
        pin3 = 1'b0;
        pend = 1'b0;
        rnd = 8'h49;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        foreach (rstTab[i]) rd(0, rstTab[i][15:8], rstTab[i][7:0]);
        chk(view.fetchCounter, 16'h0000);
        $display("reset test done");
        rnd = nx(rnd);
        wr(0, 8'h30, rnd);
        rd(1, 8'h30, rnd);
        wr(0, 8'hf0, 8'h5a);
        wr(1, 8'hf0, ~rnd);
        rd(0, 8'hf0, 8'h5a);
        rd(1, 8'hf0, ~rnd);
        seq.acc(1, 0, 1, 8'hf2, 8'h01);
        rd(0, 8'hf0, 8'h5e);
        seq.acc(1, 0, 1, 8'h87, 8'h00);
        chk(view.port0, 8'h7f);
        seq.acc(1, 0, 1, 8'ha3, 8'h01);
        chk(view.port2, 8'h08);
        wr(0, 8'h2f, 8'h00);
        seq.acc(1, 0, 1, 8'h7f, 8'h01);
        rd(0, 8'h2f, 8'h80);
        wr(0, 8'h20, 8'hff);
        seq.acc(1, 0, 1, 8'h00, 8'h00);
        rd(0, 8'h20, 8'hfe);
        seq.ev('{helperLoad: 1, helperValue: rnd, default: 0});
        chk(view.helper, rnd);
        wr(0, 8'h93, 8'ha5);
        rd(0, 8'h93, 8'h00);
        wr(0, 8'hd8, 8'hff);
        chk(view.baudHigh, 1'b1);
        rd(0, 8'hd8, 8'h80);
        $display("address space test done");
        wr(0, 8'hbf, 8'hc3);
        for (int b = 0; b < 4; b++) begin
            rnd = nx(rnd);
            wr(0, 8'hd0, 8'(b << 3));
            wr(0, 8'(b << 3), rnd);
            chk(view.bankBase, 8'(b << 3));
            chk(view.pagedAddr, {8'hc3, rnd});
        end
        // working register 1 of bank 3 as the low address byte
        rnd = nx(rnd);
        wr(0, 8'h19, rnd);
        seq.ev('{riSel: 1, default: 0});
        chk(view.pagedAddr, {8'hc3, rnd});
        repeat (6) begin
            rnd = nx(rnd);
            wr(0, 8'he0, rnd);
            chk(view.result, rnd);
            chk(view.status[0], ^rnd);
        end
        seq.ev('{resultLoad: 1, resultValue: 8'h07, default: 0});
        seq.ev('{flagsLoad: 1, carry: 1, signedWrap: 1, default: 0});
        chk(view.status, 8'h9d);
        wr(0, 8'hd0, 8'h22);
        rd(0, 8'hd0, 8'h23);
        $display("status test done");
        seq.ev('{push: 1, pushData: 8'haa, default: 0});
        chk(view.stackTop, 8'h08);
        rd(1, 8'h08, 8'haa);
        seq.ev('{push: 1, pop: 1, pushData: 8'h55, default: 0});
        seq.ev('{pop: 1, default: 0});
        chk(view.popData, 8'h55);
        chk(view.stackTop, 8'h08);
        repeat (3) seq.ev('{fetch: 1, default: 0});
        chk(view.fetchCounter, 16'h0003);
        seq.ev('{fetch: 1, pcLoad: 1, pcValue: 16'h1234, default: 0});
        chk(view.fetchCounter, 16'h1234);
        wr(0, 8'h82, 8'h34);
        wr(0, 8'h83, 8'h12);
        wr(0, 8'h84, 8'hcd);
        wr(0, 8'h85, 8'hab);
        chk(view.extPointer, 16'h1234);
        wr(0, 8'h92, 8'h01);
        chk(view.extPointer, 16'habcd);
        $display("stack and pointer test done");
        wr(0, 8'hc8, 8'h01);
        @(posedge clk);
        pin2 <= 1'b1;
        repeat (6) @(negedge clk);
        chk(act2, 1'b1);
        chk(act3, 1'b1);
        wr(0, 8'hc8, 8'h03);
        chk(view.irqPolarity, 8'h03);
        repeat (6) @(negedge clk);
        chk(act3, 1'b0);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(0, 8'haa, 8'hd9);
        chk(view.stackTop, 8'h07);
        repeat (3) @(negedge clk);
        chk(q.size(), 0);
        $display("irq and reset test done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
